// File: dsl_lock_ctrl.v
// security lock state machine with its apb register file
`timescale 1ns/1ps
`include "dsl_map.vh"

module dsl_lock_ctrl (
  input wire CLK, // core clock, 250 mhz
  input wire RST, // synchronous reset, active high
  input wire PSEL, // apb select
  input wire PENABLE, // apb access phase
  input wire PWRITE, // apb direction, high for write
  input wire [11:0] PADDR, // apb byte address
  input wire [31:0] PWDATA, // apb write data
  output wire [31:0] PRDATA, // apb read data
  output wire PREADY, // apb ready, always high
  output wire PSLVERR, // apb error on unmapped address
  output wire MEDIA_EN, // media access commands allowed
  output wire LOCKED, // device is locked
  output wire FROZEN, // device is frozen
  output wire ERASE_REQ // one-cycle request to erase all user data
);

  // ****************************************************************
  // state encoding
  // ****************************************************************
  localparam [1:0] ST_UNLOCKED = 2'h0;
  localparam [1:0] ST_LOCKED = 2'h1;
  localparam [1:0] ST_FROZEN = 2'h2;

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] pwd_q;
  reg [15:0] rev_in_q;
  reg ssp_en_q;
  reg [31:0] user_pw_q;
  reg [31:0] user_pw_d;
  reg [31:0] master_pw_q;
  reg [31:0] master_pw_d;
  reg user_set_q;
  reg user_set_d;
  reg master_set_q;
  reg master_set_d;
  reg max_lvl_q;
  reg max_lvl_d;
  reg [15:0] rev_q;
  reg [15:0] rev_d;
  reg prepared_q;
  reg prepared_d;
  reg last_abort_q;
  reg last_abort_d;
  reg last_done_q;
  reg erase_q;
  reg erase_d;
  reg miss;
  reg [31:0] rdata;
  reg [31:0] prdata_q;
  reg rd_hit;
  wire wr_acc;
  wire cmd_wr;
  wire ctrl_wr;
  wire por_evt;
  wire comreset_evt;
  wire [7:0] op;
  wire use_master;
  wire want_max;
  wire media_cmd;
  wire user_ok;
  wire master_ok;
  wire [2:0] fail_cnt;
  wire exhausted;
  wire [15:0] w128;

  // ****************************************************************
  // apb write decode
  // ****************************************************************
  // writes take effect at the access edge; the slave never waits
  assign PREADY = 1'b1;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign cmd_wr = wr_acc && (PADDR == `DSL_CMD_OFS);
  assign ctrl_wr = wr_acc && (PADDR == `DSL_CTRL_OFS);
  assign por_evt = ctrl_wr && PWDATA[`DSL_CTRL_POR_BIT];
  assign comreset_evt = ctrl_wr && PWDATA[`DSL_CTRL_COMRESET_BIT];
  assign op = PWDATA[`DSL_CMD_OP_MSB:`DSL_CMD_OP_LSB];
  assign use_master = PWDATA[`DSL_CMD_MASTER_BIT];
  assign want_max = PWDATA[`DSL_CMD_MAXLVL_BIT];
  assign media_cmd = PWDATA[`DSL_CMD_MEDIA_BIT];

  // password and revision staging registers, plus setting preservation
  always @(posedge CLK) begin
    if (RST) begin
      pwd_q <= 32'h0;
      rev_in_q <= 16'h0;
      ssp_en_q <= 1'b0;
    end else begin
      if (wr_acc && (PADDR == `DSL_PWD_OFS)) begin
        pwd_q <= PWDATA;
      end
      if (wr_acc && (PADDR == `DSL_REV_OFS)) begin
        rev_in_q <= PWDATA[15:0];
      end
      if (ctrl_wr) begin
        ssp_en_q <= PWDATA[`DSL_CTRL_SSP_BIT];
      end
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // compare the staged password with both stored passwords
  dsl_pw_match u_match (
    .presented(pwd_q),
    .user_pw(user_pw_q),
    .master_pw(master_pw_q),
    .user_set(user_set_q),
    .master_set(master_set_q),
    .user_ok(user_ok),
    .master_ok(master_ok)
  );

  // shared failure counter for unlock and erase unit mismatches
  dsl_fail_cnt u_fail (
    .clk(CLK),
    .rst(RST),
    .clear(por_evt),
    .miss(miss),
    .count_q(fail_cnt),
    .exhausted_q(exhausted)
  );

  // ****************************************************************
  // command interpreter
  // ****************************************************************
  // one command per write to the command register, judged in one cycle
  always @* begin
    state_d = state_q;
    user_pw_d = user_pw_q;
    master_pw_d = master_pw_q;
    user_set_d = user_set_q;
    master_set_d = master_set_q;
    max_lvl_d = max_lvl_q;
    rev_d = rev_q;
    prepared_d = prepared_q;
    last_abort_d = last_abort_q;
    erase_d = 1'b0;
    miss = 1'b0;
    if (por_evt) begin
      // power cycle: passwords persist, volatile state restarts
      prepared_d = 1'b0;
      last_abort_d = 1'b0;
      if (user_set_q) begin
        state_d = ST_LOCKED;
      end else begin
        state_d = ST_UNLOCKED;
      end
    end else if (comreset_evt) begin
      prepared_d = 1'b0;
      if (!ssp_en_q && user_set_q) begin
        state_d = ST_LOCKED;
      end
    end else if (cmd_wr) begin
      last_abort_d = 1'b0;
      case (op)
        `DSL_OP_SET_PW: begin
          if (state_q != ST_UNLOCKED) begin
            last_abort_d = 1'b1;
          end else if (use_master) begin
            if (rev_in_q == 16'h0000 || rev_in_q == 16'hffff) begin
              last_abort_d = 1'b1;
            end else begin
              master_pw_d = pwd_q;
              master_set_d = 1'b1;
              if (rev_in_q >= `DSL_REV_MIN && rev_in_q <= `DSL_REV_MAX) begin
                rev_d = rev_in_q;
              end
            end
          end else begin
            user_pw_d = pwd_q;
            user_set_d = 1'b1;
            max_lvl_d = want_max;
          end
        end
        `DSL_OP_UNLOCK: begin
          if (state_q == ST_FROZEN || exhausted) begin
            last_abort_d = 1'b1;
          end else if (use_master ? (master_ok && !max_lvl_q) : user_ok) begin
            state_d = ST_UNLOCKED;
          end else if (use_master && master_ok) begin
            last_abort_d = 1'b1;
          end else begin
            miss = 1'b1;
            last_abort_d = 1'b1;
          end
        end
        `DSL_OP_ERASE_PREP: begin
          if (state_q == ST_FROZEN) begin
            last_abort_d = 1'b1;
          end else begin
            prepared_d = 1'b1;
          end
        end
        `DSL_OP_ERASE_UNIT: begin
          prepared_d = 1'b0;
          if (state_q == ST_FROZEN || exhausted || !prepared_q) begin
            last_abort_d = 1'b1;
          end else if (use_master ? master_ok : user_ok) begin
            state_d = ST_UNLOCKED;
            user_set_d = 1'b0;
            max_lvl_d = 1'b0;
            erase_d = 1'b1;
          end else begin
            miss = 1'b1;
            last_abort_d = 1'b1;
          end
        end
        `DSL_OP_FREEZE: begin
          if (state_q == ST_LOCKED) begin
            last_abort_d = 1'b1;
          end else begin
            state_d = ST_FROZEN;
          end
        end
        `DSL_OP_DISABLE_PW: begin
          if (state_q != ST_UNLOCKED) begin
            last_abort_d = 1'b1;
          end else if (use_master ? (master_ok && !max_lvl_q) : user_ok) begin
            user_set_d = 1'b0;
            max_lvl_d = 1'b0;
          end else begin
            last_abort_d = 1'b1;
          end
        end
        default: begin
          // ordinary commands: media access is refused only while locked
          if (media_cmd && state_q == ST_LOCKED) begin
            last_abort_d = 1'b1;
          end
        end
      endcase
    end
  end

  // security state registers
  always @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_UNLOCKED;
      user_pw_q <= 32'h0;
      master_pw_q <= 32'h0;
      user_set_q <= 1'b0;
      master_set_q <= 1'b0;
      max_lvl_q <= 1'b0;
      rev_q <= `DSL_REV_DEFAULT;
      prepared_q <= 1'b0;
      last_abort_q <= 1'b0;
      last_done_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      user_pw_q <= user_pw_d;
      master_pw_q <= master_pw_d;
      user_set_q <= user_set_d;
      master_set_q <= master_set_d;
      max_lvl_q <= max_lvl_d;
      rev_q <= rev_d;
      prepared_q <= prepared_d;
      last_abort_q <= last_abort_d;
      erase_q <= erase_d;
      if (cmd_wr) begin
        last_done_q <= 1'b1;
      end else if (por_evt) begin
        last_done_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  // lock state seen by the command path
  assign MEDIA_EN = (state_q != ST_LOCKED);
  assign LOCKED = (state_q == ST_LOCKED);
  assign FROZEN = (state_q == ST_FROZEN);
  assign ERASE_REQ = erase_q;

  // identify word 128 image
  assign w128 = {7'h00, max_lvl_q, 3'h0, exhausted, FROZEN, LOCKED, user_set_q, 1'b1};

  // ****************************************************************
  // apb read mux
  // ****************************************************************
  // read data for the addressed register, zero elsewhere
  always @* begin
    rdata = 32'h0;
    rd_hit = 1'b1;
    case (PADDR)
      `DSL_CMD_OFS: rdata = 32'h0;
      `DSL_PWD_OFS: rdata = 32'h0;
      `DSL_REV_OFS: rdata = {16'h0, rev_in_q};
      `DSL_CTRL_OFS: rdata = {31'h0, ssp_en_q};
      `DSL_STAT_OFS: rdata = {21'h0, fail_cnt, master_set_q, user_set_q, prepared_q,
        last_done_q, last_abort_q, 1'b0, state_q};
      `DSL_IDW92_OFS: rdata = {16'h0, rev_q};
      `DSL_IDW128_OFS: rdata = {16'h0, w128};
      default: rd_hit = 1'b0;
    endcase
  end

  // read data is captured at the setup edge, so the access phase sees a flip-flop
  // value; no write shares that edge, so the captured state is never stale
  always @(posedge CLK) begin
    if (RST) begin
      prdata_q <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_q <= rdata;
    end else begin
      prdata_q <= 32'h0; // bus shows zero outside a read access
    end
  end

  // registered read data, error flag decoded in the access phase
  assign PRDATA = prdata_q;
  assign PSLVERR = PSEL && PENABLE && !rd_hit;

endmodule // dsl_lock_ctrl

// File: dsl_map.vh
// register map, field positions, reset values and opcodes of the security lock block
`ifndef DSL_MAP_VH
`define DSL_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DSL_CMD_OFS 12'h000
`define DSL_PWD_OFS 12'h004
`define DSL_REV_OFS 12'h008
`define DSL_CTRL_OFS 12'h00c
`define DSL_STAT_OFS 12'h010
`define DSL_IDW92_OFS 12'h014
`define DSL_IDW128_OFS 12'h018

// ****************************************************************
// command register fields
// ****************************************************************
`define DSL_CMD_OP_LSB 0
`define DSL_CMD_OP_MSB 7
`define DSL_CMD_MASTER_BIT 8
`define DSL_CMD_MAXLVL_BIT 9
`define DSL_CMD_MEDIA_BIT 10

// ****************************************************************
// control register fields
// ****************************************************************
`define DSL_CTRL_SSP_BIT 0
`define DSL_CTRL_POR_BIT 1
`define DSL_CTRL_COMRESET_BIT 2

// ****************************************************************
// identify word 128 fields
// ****************************************************************
`define DSL_W128_EN_BIT 1
`define DSL_W128_LOCKED_BIT 2
`define DSL_W128_FROZEN_BIT 3
`define DSL_W128_EXHAUSTED_BIT 4
`define DSL_W128_MAXLVL_BIT 8

// ****************************************************************
// security opcodes
// ****************************************************************
`define DSL_OP_SET_PW 8'hf1
`define DSL_OP_UNLOCK 8'hf2
`define DSL_OP_ERASE_PREP 8'hf3
`define DSL_OP_ERASE_UNIT 8'hf4
`define DSL_OP_FREEZE 8'hf5
`define DSL_OP_DISABLE_PW 8'hf6

// ****************************************************************
// widths, limits and reset values
// ****************************************************************
`define DSL_PW_W 32
`define DSL_REV_DEFAULT 16'hfffe
`define DSL_REV_MIN 16'h0001
`define DSL_REV_MAX 16'hfffe
`define DSL_FAIL_W 3
`define DSL_FAIL_LIMIT 3'h5

`endif

// File: dsl_pw_match.v
// password comparison against the stored user and master passwords
`timescale 1ns/1ps

module dsl_pw_match (
  input wire [31:0] presented, // password offered with the command
  input wire [31:0] user_pw, // stored user password
  input wire [31:0] master_pw, // stored master password
  input wire user_set, // a user password is in force
  input wire master_set, // a master password is in force
  output wire user_ok, // presented matches the user password
  output wire master_ok // presented matches the master password
);

  // a password only matches once it has been set
  assign user_ok = user_set && (presented == user_pw);
  assign master_ok = master_set && (presented == master_pw);

endmodule // dsl_pw_match

// File: dsl_fail_cnt.v
// saturating unlock and erase unit failure counter with its exhausted flag
`timescale 1ns/1ps
`include "dsl_map.vh"

module dsl_fail_cnt (
  input wire clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire clear, // power-on event clears count and flag
  input wire miss, // one password mismatch
  output reg [2:0] count_q, // mismatches so far
  output reg exhausted_q // attempt limit reached
);

  // count mismatches, stop at the limit and raise the flag there
  always @(posedge clk) begin
    if (rst || clear) begin
      count_q <= 3'h0;
      exhausted_q <= 1'b0;
    end else if (miss && !exhausted_q) begin
      count_q <= count_q + 3'h1;
      if (count_q + 3'h1 == `DSL_FAIL_LIMIT) begin
        exhausted_q <= 1'b1;
      end
    end
  end

endmodule // dsl_fail_cnt

// File: dsl_lock_ctrl_assertions.sv
// concurrent checks on the security lock block ports, with its bind
`timescale 1ns/1ps
`include "dsl_map.vh"

// ****
// port checker
// ****
module dsl_chk (
  input wire CLK, // core clock
  input wire RST, // sync reset
  input wire PSEL, // apb select
  input wire PENABLE, // access phase
  input wire PWRITE, // direction
  input wire [11:0] PADDR, // address
  input wire [31:0] PWDATA, // write data
  input wire PSLVERR, // bus error
  input wire MEDIA_EN, // media allowed
  input wire LOCKED, // locked
  input wire FROZEN, // frozen
  input wire ERASE_REQ // erase pulse
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // decoded writes taken at this edge
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire cmd_w = wr_acc && PADDR == `DSL_CMD_OFS;
  wire ctl_w = wr_acc && PADDR == `DSL_CTRL_OFS;
  wire f4_w = cmd_w && PWDATA[7:0] == `DSL_OP_ERASE_UNIT;

  media_gate_a: assert property (MEDIA_EN == !LOCKED)
    else $error("media enable disagrees with lock state");
  media_cause_a: assert property ($rose(MEDIA_EN) |-> $past(ctl_w) || $past(cmd_w))
    else $error("media access enabled without a command or power event");
  frozen_stays_a: assert property (FROZEN && !ctl_w |=> FROZEN)
    else $error("frozen state left by a command");
  lock_cause_a: assert property ($rose(LOCKED) |-> $past(ctl_w))
    else $error("lock entered without a power or link event");
  unlock_cause_a: assert property ($fell(LOCKED) |-> $past(ctl_w) ||
    $past(cmd_w && PWDATA[7:0] == `DSL_OP_UNLOCK) || $past(f4_w))
    else $error("unlock without unlock or erase unit");
  freeze_cause_a: assert property ($rose(FROZEN) |->
    $past(cmd_w && PWDATA[7:0] == `DSL_OP_FREEZE))
    else $error("frozen without freeze lock");
  erase_pulse_a: assert property (ERASE_REQ |=> !ERASE_REQ)
    else $error("erase request longer than one cycle");
  erase_cause_a: assert property (ERASE_REQ |-> $past(f4_w) || $past(f4_w, 2))
    else $error("erase request without erase unit");
  erase_unlocks_a: assert property (ERASE_REQ |-> !LOCKED)
    else $error("erase request while still locked");
  bad_addr_a: assert property (PSEL && PENABLE && PADDR > 12'h018 |-> PSLVERR)
    else $error("unmapped access not flagged");

  cover property ($fell(LOCKED));
  cover property (ERASE_REQ);
  cover property ($rose(FROZEN));
endmodule // dsl_chk

bind dsl_lock_ctrl dsl_chk dsl_chk_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSLVERR(PSLVERR), .MEDIA_EN(MEDIA_EN), .LOCKED(LOCKED), .FROZEN(FROZEN),
  .ERASE_REQ(ERASE_REQ));

// File: dsl_host.sv
// apb host model that issues security commands to the lock block
`timescale 1ns/1ps
`include "dsl_map.vh"

// ****
// host model
// ****
module dsl_host (
  input wire clk, // core clock
  input wire pready, // slave ready
  input wire pslverr, // slave error
  input wire [31:0] prdata, // read data
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [11:0] paddr, // address
  output logic [31:0] pwdata // write data
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // one transfer, held until pready is seen at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // password first, then opcode with its flag bits
  task cmd(input logic [7:0] op, input logic [2:0] fl, input logic [31:0] p);
    logic [31:0] q;
    logic e;
    begin
      xfer(1'b1, `DSL_PWD_OFS, p, q, e);
      xfer(1'b1, `DSL_CMD_OFS, {21'h0, fl, op}, q, e);
    end
  endtask
endmodule // dsl_host

// File: dsl_lock_ctrl_tb.sv
// self-checking bench for the security lock block
`timescale 1ns/1ps
`include "dsl_map.vh"
`define CHK(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); \
  end \
end

module dsl_lock_ctrl_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  wire psel, penable, pwrite, pready, pslverr, media_en, locked, frozen, erase_req;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int err_total = 0;
  int samples_checked = 0;
  int erase_cnt = 0;
  logic [31:0] q;
  logic e;
  logic [15:0] rsv [2] = '{16'h0000, 16'hffff};
  logic [7:0] frz [5] = '{8'hf1, 8'hf6, 8'hf2, 8'hf3, 8'hf4};
  localparam logic [31:0] MPW = 32'h1111_1111;
  localparam logic [31:0] UPW = 32'h2222_2222;

  // 250 mhz clock
  always #2 CLK = ~CLK;
  // counts erase pulses
  always @(posedge CLK) if (erase_req) erase_cnt++;

  dsl_lock_ctrl dsl_lock_ctrl_i (.CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEDIA_EN(media_en), .LOCKED(locked), .FROZEN(frozen),
    .ERASE_REQ(erase_req));
  dsl_host dsl_host_i (.clk(CLK), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ****
  // access helpers
  // ****
  task rd(input logic [11:0] a);
    dsl_host_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    dsl_host_i.xfer(1'b1, a, d, q, e);
  endtask
  // abort flag and lock state after the last command
  task st(input logic ab, input logic lk);
    begin
      rd(`DSL_STAT_OFS);
      `CHK("abort", ab, q[3])
      `CHK("locked", lk, locked)
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    finish_test;
  end

  // ****
  // test sequence
  // ****
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    st(1'b0, 1'b0);
    `CHK("media", 1'b1, media_en)
    rd(`DSL_IDW92_OFS);
    `CHK("rev default", 16'hfffe, q[15:0])
    // reserved revision codes refused
    foreach (rsv[i]) begin
      wr(`DSL_REV_OFS, {16'h0, rsv[i]});
      dsl_host_i.cmd(`DSL_OP_SET_PW, 3'b001, MPW);
      st(1'b1, 1'b0);
    end
    wr(`DSL_REV_OFS, 32'h1);
    dsl_host_i.cmd(`DSL_OP_SET_PW, 3'b001, MPW);
    rd(`DSL_IDW92_OFS);
    `CHK("rev", 16'h0001, q[15:0])
    wr(`DSL_CTRL_OFS, 32'h2);
    st(1'b0, 1'b0);
    // master password is already set before the user one
    dsl_host_i.cmd(`DSL_OP_SET_PW, 3'b000, UPW);
    st(1'b0, 1'b0);
    wr(`DSL_CTRL_OFS, 32'h2);
    st(1'b0, 1'b1);
    dsl_host_i.cmd(8'h25, 3'b100, 32'h0);
    st(1'b1, 1'b1);
    // five mismatches, master and user alternating
    for (int i = 0; i < 5; i++) begin
      dsl_host_i.cmd(`DSL_OP_UNLOCK, {2'b00, i[0]}, 32'h0bad0000 + i);
      rd(`DSL_STAT_OFS);
      `CHK("fails", 3'(i + 1), q[10:8])
      rd(`DSL_IDW128_OFS);
      `CHK("exhausted", i == 4, q[4])
    end
    dsl_host_i.cmd(`DSL_OP_UNLOCK, 3'b000, UPW);
    st(1'b1, 1'b1);
    wr(`DSL_CTRL_OFS, 32'h2);
    rd(`DSL_IDW128_OFS);
    `CHK("exhausted", 1'b0, q[4])
    rd(`DSL_STAT_OFS);
    `CHK("fails", 3'h0, q[10:8])
    dsl_host_i.cmd(`DSL_OP_UNLOCK, 3'b001, MPW);
    st(1'b0, 1'b0);
    // link reset with and without setting preservation; the preservation
    // bit is written first, since a link reset uses the value already held
    wr(`DSL_CTRL_OFS, 32'h1);
    wr(`DSL_CTRL_OFS, 32'h5);
    st(1'b0, 1'b0);
    wr(`DSL_CTRL_OFS, 32'h0);
    wr(`DSL_CTRL_OFS, 32'h4);
    st(1'b0, 1'b1);
    dsl_host_i.cmd(`DSL_OP_UNLOCK, 3'b000, UPW);
    st(1'b0, 1'b0);
    // disabling the user password leaves the next power-on unlocked
    dsl_host_i.cmd(`DSL_OP_DISABLE_PW, 3'b000, UPW);
    st(1'b0, 1'b0);
    `CHK("user set", 1'b0, q[6])
    wr(`DSL_CTRL_OFS, 32'h2);
    st(1'b0, 1'b0);
    // maximum level: the master password recovers only through erase unit
    dsl_host_i.cmd(`DSL_OP_SET_PW, 3'b010, UPW);
    rd(`DSL_IDW128_OFS);
    `CHK("max level", 1'b1, q[8])
    wr(`DSL_CTRL_OFS, 32'h2);
    dsl_host_i.cmd(`DSL_OP_FREEZE, 3'b000, 32'h0);
    st(1'b1, 1'b1);
    dsl_host_i.cmd(`DSL_OP_UNLOCK, 3'b001, MPW);
    st(1'b1, 1'b1);
    dsl_host_i.cmd(`DSL_OP_ERASE_UNIT, 3'b001, MPW);
    st(1'b1, 1'b1);
    `CHK("erase", 1'b1, erase_cnt == 0)
    dsl_host_i.cmd(`DSL_OP_ERASE_PREP, 3'b000, 32'h0);
    dsl_host_i.cmd(`DSL_OP_ERASE_UNIT, 3'b001, MPW);
    st(1'b0, 1'b0);
    `CHK("erase", 1'b1, erase_cnt == 1)
    // frozen refuses security changes only; state is looked at one edge on
    dsl_host_i.cmd(`DSL_OP_FREEZE, 3'b000, 32'h0);
    @(posedge CLK);
    `CHK("frozen", 1'b1, frozen)
    foreach (frz[i]) begin
      dsl_host_i.cmd(frz[i], 3'b000, UPW);
      st(1'b1, 1'b0);
    end
    dsl_host_i.cmd(8'h25, 3'b100, 32'h0);
    st(1'b0, 1'b0);
    wr(`DSL_CTRL_OFS, 32'h4);
    @(posedge CLK);
    `CHK("frozen", 1'b1, frozen)
    `CHK("erase", 1'b1, erase_cnt == 1)
    rd(12'h01c);
    `CHK("slverr", 1'b1, e)
    `CHK("rdata", 32'h0, q)
    finish_test;
  end
endmodule // dsl_lock_ctrl_tb
